// ---- design/rsi_ctrl.sv ----
// Status LED sequencer, serial gating and AXI4-Lite control registers
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module rsi_ctrl
    import rsi_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // AXI4-Lite slave
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Radio core events, same clock
    input wire logic rf_traffic,
    input wire logic rf_seq_match,
    input wire logic rf_tx_pkt,
    // Radio core serial data path
    input wire logic core_txd,
    input wire logic core_cts,
    output logic core_rxd,
    output logic [13:0] baud_div,
    // RS-232 DCE pins
    output logic ser_txd,
    output logic ser_cts,
    input wire logic ser_rxd,
    // Indicators
    output logic red_led,
    output logic green_led
);
    // Elaboration check: the divider needs at least two cycles
    if (TICK_DIV < 2) begin : g_bad_div
        $error("rsi_ctrl: TICK_DIV must be at least 2");
    end

    // Millisecond enable from the divider
    logic tick;
    rsi_tick_div #(.DIV(TICK_DIV)) u_div (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .tick(tick)
    );

    // ---------------- Register file ----------------
    rsi_cfg_s cfg;
    rsi_stat_s stat;
    logic aw_hold;
    logic w_hold;
    logic [3:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    // Write channels ready while their own beat is not parked and no response pending; read while no read data pending
    assign s_axi_awready = !aw_hold && !s_axi_bvalid;
    assign s_axi_wready = !w_hold && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    wire aw_fire = s_axi_awvalid && s_axi_awready;
    wire w_fire = s_axi_wvalid && s_axi_wready;
    wire ar_fire = s_axi_arvalid && s_axi_arready;
    wire wr_go = aw_hold && w_hold && !s_axi_bvalid;
    wire wr_ctrl = wr_go && (aw_addr == ADDR_CTRL);

    // Byte-lane merge of the write into the control word
    wire [31:0] lane_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
    // Baud at bits 10:8, three spare zero bits under it
    wire [31:0] ctrl_word = 32'({cfg.baud, 3'h0, cfg.active_if, cfg.mode});
    wire [31:0] merged = (ctrl_word & ~lane_mask) | (w_data & lane_mask);
    wire [1:0] new_mode = merged[MODE_LSB +: 2];
    wire [2:0] new_if = merged[IF_LSB +: 3];
    wire [2:0] new_baud = merged[BAUD_LSB +: 3];
    // Unsupported codes leave the field as it was
    wire if_ok = (new_if <= 3'(IF_ROUTER));
    wire baud_ok = (new_baud <= 3'(B115200));

    // Parked write address and data, taken in either order
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr <= 4'h0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else begin
            if (aw_fire) begin
                aw_hold <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_hold <= 1'b0;
            end
            if (w_fire) begin
                w_hold <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_go) begin
                w_hold <= 1'b0;
            end
        end
    end

    // Write response; only control is writable
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ctrl ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Configuration is written from the bus alone
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg <= rsi_cfg_s'({CTRL_RST[BAUD_LSB +: 3], CTRL_RST[IF_LSB +: 3],
                               CTRL_RST[MODE_LSB +: 2]});
        end else if (wr_ctrl) begin
            cfg.mode <= new_mode;
            if (if_ok) cfg.active_if <= new_if;
            if (baud_ok) cfg.baud <= new_baud;
        end
    end

    // Read data path
    wire [31:0] rd_word = (s_axi_araddr == ADDR_CTRL) ? ctrl_word :
                          (s_axi_araddr == ADDR_STAT) ? 32'(stat) : 32'h0000_0000;
    wire rd_hit = (s_axi_araddr == ADDR_CTRL) || (s_axi_araddr == ADDR_STAT);

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (ar_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ---------------- Indicator timing ----------------
    logic [13:0] up_ms;
    logic [12:0] phase;
    logic [7:0] tx_off;
    logic startup_done;

    // Uptime saturates once start-up is over
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            up_ms <= 14'h0000;
            startup_done <= 1'b0;
        end else if (tick && !startup_done) begin
            up_ms <= up_ms + 14'h0001;
            startup_done <= (up_ms == STARTUP_MS - 14'h0001);
        end
    end

    // Single free-running phase; longest period is a multiple of the others
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            phase <= 13'h0000;
        end else if (tick) begin
            phase <= (phase == PER_C_MS - 13'h0001) ? 13'h0000 : phase + 13'h0001;
        end
    end

    // Transmit blanking window, restarted by each packet
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_off <= 8'h00;
        end else if (rf_tx_pkt) begin
            tx_off <= TX_OFF_MS;
        end else if (tick && tx_off != 8'h00) begin
            tx_off <= tx_off - 8'h01;
        end
    end

    // Flash window at the start of each listening period
    wire [12:0] ph_a = phase % PER_A_MS;
    wire [12:0] ph_b = phase % PER_B_MS;
    wire flash_a = ph_a < FLASH_MS;
    wire flash_b = ph_b < FLASH_MS;
    wire flash_c = phase < FLASH_MS;
    wire listen = (cfg.mode == 2'(PM_ALWAYS)) ? 1'b1 :
                  (cfg.mode == 2'(PM_HALF)) ? flash_a :
                  (cfg.mode == 2'(PM_ONE)) ? flash_b : flash_c;
    wire blank = (tx_off != 8'h00) || rf_tx_pkt;
    // Blanking beats traffic so the LED is never solid while sending
    wire run_red = blank ? 1'b0 : (rf_traffic || listen);
    wire next_red = startup_done ? run_red : 1'b1;
    wire green_win = (up_ms >= GREEN_ON_MS) && (up_ms < GREEN_OFF_MS);
    wire next_green = startup_done ? rf_seq_match : green_win;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            red_led <= 1'b1;
            green_led <= 1'b0;
        end else begin
            red_led <= next_red;
            green_led <= next_green;
        end
    end

    // ---------------- Serial port gating ----------------
    logic rx_s1;
    logic rx_s2;
    logic serial_en;
    wire next_txd = serial_en ? core_txd : 1'b1;
    wire next_cts = serial_en && core_cts;

    // Pin sync; idle mark level at reset
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_s1 <= 1'b1;
            rx_s2 <= 1'b1;
        end else begin
            rx_s1 <= ser_rxd;
            rx_s2 <= rx_s1;
        end
    end

    // Data passes only with the port selected; rx feeds data, never config
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            serial_en <= 1'b0;
            ser_txd <= 1'b1;
            ser_cts <= 1'b0;
            core_rxd <= 1'b1;
            baud_div <= 14'h0000;
        end else begin
            serial_en <= (cfg.active_if == 3'(IF_RS232));
            ser_txd <= next_txd;
            ser_cts <= next_cts;
            core_rxd <= serial_en ? rx_s2 : 1'b1;
            baud_div <= rsi_baud_div(cfg.baud);
        end
    end

    assign stat = '{traffic: rf_traffic, serial_en: serial_en,
                    startup_done: startup_done, green: green_led, red: red_led};

    // ---------------- Assertions ----------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    property p_start_red;
        !startup_done |=> red_led;
    endproperty
    a_start_red: assert property (p_start_red) else $error("red dark during start-up");

    property p_green_win;
        !startup_done |=> (green_led == $past(green_win));
    endproperty
    a_green_win: assert property (p_green_win) else $error("green start-up pulse wrong");

    property p_handover;
        $rose(startup_done) |-> (up_ms == STARTUP_MS);
    endproperty
    a_handover: assert property (p_handover) else $error("start-up ended at wrong time");

    property p_always_on;
        startup_done && cfg.mode == 2'(PM_ALWAYS) && !blank |=> red_led;
    endproperty
    a_always_on: assert property (p_always_on) else $error("always-on mode not solid");

    property p_flash_off;
        startup_done && cfg.mode == 2'(PM_EIGHT) && !rf_traffic && phase >= FLASH_MS
            |=> !red_led;
    endproperty
    a_flash_off: assert property (p_flash_off) else $error("red lit outside flash");

    property p_traffic;
        startup_done && rf_traffic && !blank |=> red_led;
    endproperty
    a_traffic: assert property (p_traffic) else $error("traffic did not hold red");

    property p_tx_blank;
        startup_done && rf_tx_pkt |=> !red_led [*2];
    endproperty
    a_tx_blank: assert property (p_tx_blank) else $error("transmit did not blank red");

    property p_green_match;
        startup_done ##1 startup_done && ($past(rf_seq_match) != green_led) |-> 1'b0;
    endproperty
    a_green_match: assert property (p_green_match) else $error("green not tracking match");

    property p_gate;
        !serial_en |=> ser_txd && !ser_cts && core_rxd;
    endproperty
    a_gate: assert property (p_gate) else $error("serial active while deselected");

    property p_cfg_bus_only;
        !wr_ctrl |=> $stable(cfg);
    endproperty
    a_cfg_bus_only: assert property (p_cfg_bus_only) else $error("config changed off-bus");

    property p_baud;
        $changed(cfg.baud) |=> (baud_div == rsi_baud_div($past(cfg.baud)));
    endproperty
    a_baud: assert property (p_baud) else $error("baud divisor mismatch");

    property p_wrap;
        tick && phase == PER_C_MS - 13'h0001 |=> phase == 13'h0000;
    endproperty
    a_wrap: assert property (p_wrap) else $error("phase counter wrap wrong");

    property p_tx_hold;
        startup_done && tx_off != 8'h00 |=> !red_led;
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("red lit inside transmit blank");

    property p_serial_pass;
        serial_en |=> ser_txd == $past(core_txd) && core_rxd == $past(rx_s2);
    endproperty
    a_serial_pass: assert property (p_serial_pass) else $error("serial data not passed");

    c_done: cover property ($rose(startup_done));
    c_tx: cover property (startup_done && rf_tx_pkt && rf_traffic);
    c_write: cover property (wr_ctrl && if_ok && new_if == 3'(IF_RS232));
    c_flash: cover property (startup_done && cfg.mode == 2'(PM_HALF) && phase == 13'h0000);
    c_serial: cover property (serial_en && !rx_s2);
endmodule : rsi_ctrl
`default_nettype wire

// ---- design/rsi_pkg.sv ----
// Constants, types and helpers for the radio status indicator block
//
// Operation
// - Red lit solid ten seconds after power-up.
// - Green lit one second, three seconds in.
// - After ten seconds mode pattern drives red.
// - Red shows listening; always-on mode keeps solid.
// - Duty modes flash red every 0.5/1/8 s.
// - Matching RF traffic holds red steadily on.
// - Each transmitted packet blanks red briefly.
// - Green follows received hopping-sequence match.
// - Serial port carries data only when selected.
// - Serial port never reaches configuration.
// - DCE drives TX and CTS, samples RX.
// - Baud rates 1200 to 115200 selectable.
`default_nettype none
package rsi_pkg;
    localparam int CLK_HZ = 10_000_000;
    // Indicator time base: one tick per millisecond
    localparam int TICK_MS = 1;
    localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    // Start-up sequence, seconds as specified, then in ticks
    localparam int STARTUP_S = 10;
    localparam int GREEN_AT_S = 3;
    localparam int GREEN_LEN_S = 1;
    localparam logic [13:0] STARTUP_MS = 14'(STARTUP_S * 1000 / TICK_MS);
    localparam logic [13:0] GREEN_ON_MS = 14'(GREEN_AT_S * 1000 / TICK_MS);
    localparam logic [13:0] GREEN_OFF_MS = 14'((GREEN_AT_S + GREEN_LEN_S) * 1000 / TICK_MS);
    // Listening periods: 0.5 s, 1 s and 8 s
    localparam logic [12:0] PER_A_MS = 13'd500;
    localparam logic [12:0] PER_B_MS = 13'd1000;
    localparam logic [12:0] PER_C_MS = 13'd8000;
    localparam logic [12:0] FLASH_MS = 13'd50;
    localparam logic [7:0] TX_OFF_MS = 8'd40;
    // Register byte addresses
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STAT = 4'h4;
    // Control field positions and reset value
    localparam int MODE_LSB = 0;
    localparam int IF_LSB = 2;
    localparam int BAUD_LSB = 8;
    localparam logic [31:0] CTRL_RST = 32'h0000_020c;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {PM_ALWAYS, PM_HALF, PM_ONE, PM_EIGHT} rsi_mode_e;
    typedef enum logic [2:0] {IF_SDC, IF_ME, IF_RS232, IF_USB, IF_ROUTER} rsi_if_e;
    typedef enum logic [2:0] {B1200, B4800, B9600, B19200, B38400, B57600,
                              B115200} rsi_baud_e;

    typedef struct packed {
        logic [2:0] baud;
        logic [2:0] active_if;
        logic [1:0] mode;
    } rsi_cfg_s;

    typedef struct packed {
        logic traffic;
        logic serial_en;
        logic startup_done;
        logic green;
        logic red;
    } rsi_stat_s;

    // Clock cycles per serial bit for a baud code
    function automatic logic [13:0] rsi_baud_div(input logic [2:0] code);
        int rate;
        case (code)
            3'd0: rate = 1200;
            3'd1: rate = 4800;
            3'd2: rate = 9600;
            3'd3: rate = 19200;
            3'd4: rate = 38400;
            3'd5: rate = 57600;
            default: rate = 115200;
        endcase
        return 14'(CLK_HZ / rate);
    endfunction : rsi_baud_div
endpackage : rsi_pkg
`default_nettype wire

// ---- design/rsi_tick_div.sv ----
// Clock divider producing a one-cycle tick enable
`timescale 1ns/1ns
`default_nettype none
module rsi_tick_div #(
    parameter int DIV = 10000
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Enable pulse
    output logic tick
);
    localparam int W = $clog2(DIV);
    logic [W-1:0] cnt;
    wire last = (cnt == W'(DIV - 1));

    // Elaboration check: a divide by one would never pulse
    if (DIV < 2) begin : g_bad_div
        $error("rsi_tick_div: DIV must be at least 2");
    end

    // Free-running count, pulse on wrap
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt <= '0;
            tick <= 1'b0;
        end else begin
            cnt <= last ? '0 : cnt + 1'b1;
            tick <= last;
        end
    end
endmodule : rsi_tick_div
`default_nettype wire

// ---- tb/rsi_dte_model.sv ----
// Terminal model facing the radio's DCE serial port
`timescale 1ns/1ns
`default_nettype none
module rsi_dte_model (
    // Clock
    input wire logic ref_clk,
    // Bit time chosen by the radio
    input wire logic [13:0] baud_div,
    // DCE pins seen from the terminal side
    input wire logic ser_txd,
    input wire logic ser_cts,
    output var logic ser_rxd
);
    // Last levels the radio showed on its outputs, sampled not driven
    logic [1:0] seen;

    initial ser_rxd = 1'b1;

    // Terminal only listens on TX and CTS
    always @(posedge ref_clk) begin
        seen <= {ser_cts, ser_txd};
    end

    // Hold the data line at a level between frames
    task automatic set_rx(input logic v);
        @(posedge ref_clk);
        ser_rxd <= v;
    endtask : set_rx

    // One 8N1 frame, LSB first, at the rate the radio is set to
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] fr;
        fr = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge ref_clk);
            ser_rxd <= fr[i];
            repeat (int'(baud_div) - 1) @(posedge ref_clk);
        end
    endtask : send_byte
endmodule : rsi_dte_model
`default_nettype wire

// ---- tb/test_radio_status_indicator_control.sv ----
// Self-checking bench for the status indicator and serial gating block
`timescale 1ns/1ns
`default_nettype none
module test_radio_status_indicator_control;
    import rsi_pkg::*;
    // Short tick so ten seconds is 20000 cycles
    localparam int TD = 2;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] awaddr = 4'h0;
    logic [3:0] araddr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic rf_traffic = 1'b0, rf_seq_match = 1'b0, rf_tx_pkt = 1'b0;
    logic core_txd = 1'b1, core_cts = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, core_rxd, ser_txd, ser_cts, ser_rxd;
    logic red_led, green_led;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [13:0] baud_div;
    int n_errors = 0;
    int checks = 0;
    int cyc = 0;

    rsi_ctrl #(.TICK_DIV(TD)) dut_u (.ref_clk(ref_clk), .reset_n(reset_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rf_traffic(rf_traffic),
        .rf_seq_match(rf_seq_match), .rf_tx_pkt(rf_tx_pkt), .core_txd(core_txd),
        .core_cts(core_cts), .core_rxd(core_rxd), .baud_div(baud_div),
        .ser_txd(ser_txd), .ser_cts(ser_cts), .ser_rxd(ser_rxd),
        .red_led(red_led), .green_led(green_led));

    rsi_dte_model dte_u (.ref_clk(ref_clk), .baud_div(baud_div), .ser_txd(ser_txd),
        .ser_cts(ser_cts), .ser_rxd(ser_rxd));

    // 10 MHz clock and a cycle count from reset release
    always #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (reset_n) cyc <= cyc + 1;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Counts of LED cycles vary by a tick, so allow a band
    task automatic chk_rng(input int got, input int lo, input int hi);
        checks++;
        if (got < lo || got > hi) begin
            n_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, lo);
        end
    endtask : chk_rng

    // Address and data offered together, each dropped once taken
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        bit pa = 1;
        bit pw = 1;
        r = 2'h3;
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge ref_clk);
            if (pa && awready) begin
                pa = 0;
                awvalid <= 1'b0;
            end
            if (pw && wready) begin
                pw = 0;
                wvalid <= 1'b0;
            end
            if (bvalid === 1'b1) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask : axi_wr

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        bit pa = 1;
        r = 2'h3;
        d = 32'hdead_beef;
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge ref_clk);
            if (pa && arready) begin
                pa = 0;
                arvalid <= 1'b0;
            end
            if (rvalid === 1'b1) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask : axi_rd

    task automatic cnt_red(input int len, output int n);
        n = 0;
        repeat (len) begin
            @(posedge ref_clk);
            if (red_led === 1'b1) n++;
        end
    endtask : cnt_red

    // Reset values, refused places, then slowest mode set inside start-up
    task automatic t_regs();
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(ADDR_CTRL, d, r);
        chk(d, CTRL_RST);
        axi_rd(ADDR_STAT, d, r);
        chk({29'h0, d[2:0]}, 32'h1);
        axi_wr(ADDR_STAT, 32'h0, r);
        chk(32'(r), 32'(RESP_SLVERR));
        axi_rd(4'h8, d, r);
        chk(d, 32'h0);
        chk(32'(r), 32'(RESP_SLVERR));
        axi_wr(ADDR_CTRL, 32'h0000_020f, r);
    endtask : t_regs

    // Red solid and one green pulse regardless of the chosen mode
    task automatic t_startup();
        logic [31:0] d;
        logic [1:0] r;
        int n_g = 0;
        int first_g = 0;
        bit drop = 0;
        while (cyc < 20100) begin
            @(posedge ref_clk);
            if (red_led !== 1'b1 && cyc < 19990) drop = 1;
            if (green_led === 1'b1) begin
                n_g++;
                if (first_g == 0) first_g = cyc;
            end
        end
        chk(32'(drop), 32'h0);
        chk_rng(first_g, 5996, 6008);
        chk_rng(n_g, 1996, 2004);
        axi_rd(ADDR_STAT, d, r);
        chk({31'h0, d[2]}, 32'h1);
    endtask : t_startup

    // One flash of 50 ticks in every listening period of the duty modes; always-on mode counted solid
    task automatic t_modes();
        int per[4] = '{16000, 1000, 2000, 1000};
        int exp[4] = '{100, 100, 100, 1000};
        logic [1:0] mode[4] = '{2'd3, 2'd1, 2'd2, 2'd0};
        logic [1:0] r;
        int n;
        for (int i = 0; i < 4; i++) begin
            if (i > 0) axi_wr(ADDR_CTRL, 32'h0000_020c | 32'(mode[i]), r);
            repeat (10) @(posedge ref_clk);
            cnt_red(per[i], n);
            chk_rng(n, exp[i] - 3, exp[i] + 3);
        end
    endtask : t_modes

    // Traffic holds red, a sent packet blanks it, green follows the match
    task automatic t_rf();
        logic [1:0] r;
        int n;
        rf_traffic <= 1'b1;
        axi_wr(ADDR_CTRL, 32'h0000_020f, r);
        repeat (5) @(posedge ref_clk);
        cnt_red(3000, n);
        chk_rng(n, 3000, 3000);
        @(posedge ref_clk);
        rf_tx_pkt <= 1'b1;
        @(posedge ref_clk);
        rf_tx_pkt <= 1'b0;
        cnt_red(200, n);
        chk_rng(200 - n, 76, 86);
        chk(32'(red_led), 32'h1);
        rf_traffic <= 1'b0;
        rf_seq_match <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk(32'(green_led), 32'h1);
        rf_seq_match <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk(32'(green_led), 32'h0);
    endtask : t_rf

    // Every rate code gives the matching bit time
    task automatic t_baud();
        int rate[7] = '{1200, 4800, 9600, 19200, 38400, 57600, 115200};
        logic [1:0] r;
        logic [31:0] d;
        chk(32'(baud_div), 32'(CLK_HZ / 9600));
        for (int i = 0; i < 7; i++) begin
            axi_wr(ADDR_CTRL, 32'h0000_000c | (32'(i) << 8), r);
            repeat (3) @(posedge ref_clk);
            chk(32'(baud_div), 32'(CLK_HZ / rate[i]));
        end
        axi_wr(ADDR_CTRL, 32'h0000_071c, r);
        axi_rd(ADDR_CTRL, d, r);
        chk(d, 32'h0000_060c);
    endtask : t_baud

    // Port quiet until selected, then TX/CTS out and RX in, never config
    task automatic t_serial();
        logic [31:0] d;
        logic [1:0] r;
        dte_u.set_rx(1'b0);
        core_txd <= 1'b0;
        core_cts <= 1'b1;
        repeat (6) @(posedge ref_clk);
        chk({29'h0, ser_txd, ser_cts, core_rxd}, 32'h5);
        axi_wr(ADDR_CTRL, 32'h0000_0608, r);
        repeat (6) @(posedge ref_clk);
        chk({29'h0, ser_txd, ser_cts, core_rxd}, 32'h2);
        core_txd <= 1'b1;
        repeat (6) @(posedge ref_clk);
        chk({29'h0, ser_txd, ser_cts, core_rxd}, 32'h6);
        chk(32'(dte_u.seen), 32'h3);
        dte_u.send_byte(8'h0d);
        repeat (10) @(posedge ref_clk);
        chk(32'(core_rxd), 32'h1);
        axi_rd(ADDR_CTRL, d, r);
        chk(d, 32'h0000_0608);
        axi_rd(ADDR_STAT, d, r);
        chk({31'h0, d[3]}, 32'h1);
    endtask : t_serial

    task automatic complete_run();
        if (n_errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run

    // Main sequence after 20 cycles of reset
    initial begin
        repeat (20) @(posedge ref_clk);
        reset_n <= 1'b1;
        t_regs();
        t_startup();
        t_modes();
        t_rf();
        t_baud();
        t_serial();
        complete_run();
    end

    // Run needs about 44500 cycles; a hang is cut at 60000
    initial begin
        #(100 * 60000);
        n_errors++;
        complete_run();
    end
endmodule : test_radio_status_indicator_control
`default_nettype wire
